// ==== core/lcd_host_pkg.sv ====
// Constants and decode helpers for the LCD controller host port.
// Assumes a 200 MHz core clock and a separate host shift clock.
//
// Contract
// RQ1: Writes accepted only while chip select low.
// RQ2: Deselected: outputs float, strobes read high.
// RQ3: Parallel byte captured at write strobe rise.
// RQ4: Serial write strobe latches shifted byte; idles high.
// RQ5: Parallel read, data select: display byte out.
// RQ6: Parallel read, command select: busy on bit0.
// RQ7: Busy rises after write, clears by itself.
// RQ8: Busy interval is a parameterised cycle count.
// RQ9: Command/data select sampled at write strobe rise.
// RQ10: Data bus floats except while read low.
// RQ11: Serial bit shifted in per shift clock rise.
// RQ12: Only last eight shifted bits are latched.
// RQ13: Sample on rising, update output on falling.
// RQ14: Serial out shifts addressed display byte.
// RQ15: Parallel mode keeps serial out floating.
// RQ16: Host ties unused port pins to levels.
// RQ17: Mode strap: low parallel, high serial, fixed.
// RQ18: Duty strap high 1/9, low 1/16.
// RQ19: Reset returns block to initial state.
// RQ20: Contrast range strap gives steps 0-7..3-A.
// RQ21: Board holds oscillator source select low.
// RQ22: Board ties test input low or open.
// RQ23: Pointer advances after data, AINC, CHB.
package lcd_host_pkg;
	localparam int DATA_W = 8;
	localparam int PTR_W = 6;
	localparam int CNT_W = 16;
	localparam int COM_N = 16;
	localparam int CRNG_W = 4;
	localparam logic [CNT_W-1:0] BUSY_CYCLES_DFLT = 16'h0040;
	localparam logic [7:0] LPA_MASK = 8'hC0;
	localparam logic [7:0] LPA_VAL = 8'hC0;
	localparam logic [7:0] AINC_MASK = 8'hEE;
	localparam logic [7:0] AINC_VAL = 8'h8A;
	localparam logic [7:0] CHB_MASK = 8'hEC;
	localparam logic [7:0] CHB_VAL = 8'h00;
	localparam logic [COM_N-1:0] COM_EN_NINE = 16'h01FF;
	localparam logic [COM_N-1:0] COM_EN_SIXTEEN = 16'hFFFF;
	localparam logic [CRNG_W-1:0] CONTRAST_SPAN = 4'h7;
	localparam logic MODE_PARALLEL = 1'b0;
	localparam logic DUTY_NINE = 1'b1;
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_LOAD = 2'b11
	} busy_state_t;

	function automatic logic cmd_match(input logic [7:0] b, input logic [7:0] m,
			input logic [7:0] v);
		return (b & m) == v;
	endfunction
endpackage

// ==== core/lcd_serial_link.sv ====
// Serial link logic clocked by the host shift clock.
// Assumes the shift clock idles high and pauses outside transfers.
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_link (
	// Link clock and core reset
	input wire logic shift_clock_in_i,
	input wire logic reset_i,
	// Host pins
	input wire logic chip_sel_n_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	// Core side
	input wire logic busy_i,
	input wire logic load_tgl_i,
	input wire logic [lcd_host_pkg::DATA_W-1:0] tx_byte_i,
	output logic [lcd_host_pkg::DATA_W-1:0] rx_byte_o
);
	import lcd_host_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] sr;
	} rx_state_t;

	typedef struct packed {
		logic rst_m;
		logic rst_q;
		logic bsy_m;
		logic bsy_q;
		logic tg_m;
		logic tg_q;
		logic seen;
		logic [2:0] idx;
		logic so;
	} tx_state_t;

	rx_state_t r_q, r_d;
	tx_state_t t_q, t_d;

	// Receive shifter, rising edges only
	always_comb begin
		r_d = r_q;
		if (!chip_sel_n_i) begin
			r_d.sr = {r_q.sr[DATA_W-2:0], serial_in_i}; // [RQ11] [RQ12] [RQ2]
		end
	end

	always_ff @(posedge shift_clock_in_i) begin
		r_q <= r_d; // [RQ13]
	end

	assign rx_byte_o = r_q.sr;

	// Transmit side, falling edges only
	always_comb begin
		t_d = t_q;
		t_d.rst_m = reset_i;
		t_d.rst_q = t_q.rst_m;
		t_d.bsy_m = busy_i;
		t_d.bsy_q = t_q.bsy_m;
		t_d.tg_m = load_tgl_i;
		t_d.tg_q = t_q.tg_m;
		if (t_q.rst_q) begin
			t_d.seen = 1'b0;
			t_d.idx = 3'h0;
			t_d.so = 1'b1;
		end else if (t_q.bsy_q) begin
			t_d.so = 1'b1; // [RQ7]
		end else if (t_q.tg_q != t_q.seen) begin
			t_d.seen = t_q.tg_q;
			t_d.so = tx_byte_i[DATA_W-1]; // [RQ14]
			t_d.idx = 3'h1;
		end else begin
			t_d.so = tx_byte_i[3'h7 - t_q.idx]; // [RQ14]
			t_d.idx = t_q.idx + 3'h1;
		end
	end

	always_ff @(negedge shift_clock_in_i) begin
		t_q <= t_d; // [RQ13]
	end

	assign serial_out_o = t_q.so;
endmodule // lcd_serial_link
`default_nettype wire

// ==== core/lcd_host_port.sv ====
// Host port of a dot-matrix LCD controller: parallel or serial.
// Assumes display RAM answers rd_byte_i for addr_ptr_o in the core clock.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_port #(
	parameter logic [lcd_host_pkg::CNT_W-1:0] BUSY_CYCLES = lcd_host_pkg::BUSY_CYCLES_DFLT
) (
	// Core clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Link clock
	input wire logic shift_clock_in_i,
	// Host strobes
	input wire logic chip_sel_n_i,
	input wire logic wr_strobe_n_i,
	input wire logic rd_strobe_n_i,
	input wire logic cmd_data_sel_i,
	// Parallel data bus
	input wire logic [lcd_host_pkg::DATA_W-1:0] host_data_bus_i,
	output logic [lcd_host_pkg::DATA_W-1:0] host_data_bus_o,
	output logic host_data_bus_oe_o,
	// Serial pins
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	// Straps
	input wire logic port_mode_sel_i,
	input wire logic duty_sel_i,
	input wire logic contrast_range_b1_i,
	input wire logic contrast_range_b0_i,
	// Written bytes towards the command and RAM logic
	output logic wr_valid_o,
	output logic wr_cmd_o,
	output logic [lcd_host_pkg::DATA_W-1:0] wr_byte_o,
	output logic [lcd_host_pkg::PTR_W-1:0] addr_ptr_o,
	output logic busy_o,
	// Display RAM read data
	input wire logic [lcd_host_pkg::DATA_W-1:0] rd_byte_i,
	// Strap-derived configuration
	output logic serial_mode_o,
	output logic duty_nine_o,
	output logic [lcd_host_pkg::COM_N-1:0] com_enable_o,
	output logic [lcd_host_pkg::CRNG_W-1:0] contrast_min_o,
	output logic [lcd_host_pkg::CRNG_W-1:0] contrast_max_o
);
	import lcd_host_pkg::*;

	typedef struct packed {
		logic cs_m;
		logic cs_q;
		logic wr_m;
		logic wr_q;
		logic wr_p;
		logic rd_m;
		logic rd_q;
		logic cd_m;
		logic cd_q;
		logic [DATA_W-1:0] db_m;
		logic [DATA_W-1:0] db_q;
		logic [3:0] strap_m;
		logic [3:0] strap_q;
		logic [1:0] strap_cnt;
		logic strap_done;
		logic mode;
		logic duty;
		logic [1:0] crng;
		busy_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [PTR_W-1:0] ptr;
		logic wv;
		logic wcmd;
		logic [DATA_W-1:0] wbyte;
		logic [DATA_W-1:0] dbo;
		logic [DATA_W-1:0] obyte;
		logic tgl;
	} port_state_t;

	port_state_t s_q, s_d;
	logic [DATA_W-1:0] rx_byte;
	logic wr_int;
	logic wr_rise;
	logic accept;
	logic [DATA_W-1:0] in_byte;
	logic busy;

	lcd_serial_link u_link (
		.shift_clock_in_i(shift_clock_in_i),
		.reset_i(reset_i),
		.chip_sel_n_i(chip_sel_n_i),
		.serial_in_i(serial_in_i),
		.serial_out_o(serial_out_o),
		.busy_i(busy),
		.load_tgl_i(s_q.tgl),
		.tx_byte_i(s_q.obyte),
		.rx_byte_o(rx_byte)
	);

	assign busy = (s_q.st != ST_IDLE);
	// Deselect forces the write strobe high internally
	assign wr_int = s_q.wr_q | s_q.cs_q; // [RQ2]
	assign wr_rise = s_q.strap_done & wr_int & ~s_q.wr_p; // [RQ3] [RQ4]
	assign accept = wr_rise & ~s_q.cs_q; // [RQ1]
	assign in_byte = (s_q.mode == MODE_PARALLEL) ? s_q.db_q : rx_byte; // [RQ3] [RQ11]

	always_comb begin
		s_d = s_q;
		// Pin synchronisers
		s_d.cs_m = chip_sel_n_i;
		s_d.cs_q = s_q.cs_m;
		s_d.wr_m = wr_strobe_n_i;
		s_d.wr_q = s_q.wr_m;
		s_d.wr_p = wr_int;
		s_d.rd_m = rd_strobe_n_i;
		s_d.rd_q = s_q.rd_m;
		s_d.cd_m = cmd_data_sel_i;
		s_d.cd_q = s_q.cd_m;
		s_d.db_m = host_data_bus_i;
		s_d.db_q = s_q.db_m;
		s_d.strap_m = {port_mode_sel_i, duty_sel_i, contrast_range_b1_i,
			contrast_range_b0_i};
		s_d.strap_q = s_q.strap_m;
		// Straps caught once after reset release
		if (!s_q.strap_done) begin
			if (s_q.strap_cnt == STRAP_WAIT) begin
				s_d.mode = s_q.strap_q[3]; // [RQ17]
				s_d.duty = s_q.strap_q[2]; // [RQ18]
				s_d.crng = s_q.strap_q[1:0]; // [RQ20]
				s_d.strap_done = 1'b1;
			end else begin
				s_d.strap_cnt = s_q.strap_cnt + 2'h1;
			end
		end
		// Busy interval
		s_d.wv = 1'b0;
		case (s_q.st)
			ST_IDLE: begin
				s_d.cnt = '0;
			end
			ST_BUSY: begin
				if (s_q.cnt == BUSY_CYCLES - 16'h0001) begin
					s_d.st = ST_LOAD; // [RQ8]
				end else begin
					s_d.cnt = s_q.cnt + 16'h0001; // [RQ8]
				end
			end
			ST_LOAD: begin
				s_d.obyte = rd_byte_i; // [RQ14]
				s_d.tgl = ~s_q.tgl;
				s_d.st = ST_IDLE; // [RQ7]
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		// Accepted write
		if (accept) begin
			s_d.wv = 1'b1;
			s_d.wcmd = s_q.cd_q; // [RQ9]
			s_d.wbyte = in_byte; // [RQ3] [RQ4]
			s_d.st = ST_BUSY; // [RQ7]
			s_d.cnt = '0;
			if (!s_q.cd_q) begin
				s_d.ptr = s_q.ptr + 6'h01; // [RQ23]
			end else if (cmd_match(in_byte, LPA_MASK, LPA_VAL)) begin
				s_d.ptr = in_byte[PTR_W-1:0];
			end else if (cmd_match(in_byte, AINC_MASK, AINC_VAL) ||
					cmd_match(in_byte, CHB_MASK, CHB_VAL)) begin
				s_d.ptr = s_q.ptr + 6'h01; // [RQ23]
			end
		end
		// Read data, registered every cycle
		if (s_q.cd_q) begin
			s_d.dbo = {7'h00, busy}; // [RQ6]
		end else begin
			s_d.dbo = rd_byte_i; // [RQ5]
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_q <= '0; // [RQ19]
		end else begin
			s_q <= s_d;
		end
	end

	assign host_data_bus_o = s_q.dbo;
	assign host_data_bus_oe_o = s_q.strap_done & (s_q.mode == MODE_PARALLEL) &
		~s_q.cs_q & ~s_q.rd_q; // [RQ10] [RQ2]
	assign serial_out_oe_o = s_q.strap_done & (s_q.mode != MODE_PARALLEL) &
		~s_q.cs_q; // [RQ15] [RQ2]
	assign wr_valid_o = s_q.wv;
	assign wr_cmd_o = s_q.wcmd;
	assign wr_byte_o = s_q.wbyte;
	assign addr_ptr_o = s_q.ptr;
	assign busy_o = busy;
	assign serial_mode_o = s_q.mode;
	assign duty_nine_o = (s_q.duty == DUTY_NINE);
	assign com_enable_o = (s_q.duty == DUTY_NINE) ? COM_EN_NINE : COM_EN_SIXTEEN; // [RQ18]
	assign contrast_min_o = {2'b00, s_q.crng}; // [RQ20]
	assign contrast_max_o = {2'b00, s_q.crng} + CONTRAST_SPAN; // [RQ20]

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	property p_busy_set;
		wr_valid_o |-> busy_o;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set after write"); // [RQ7]

	sequence s_busy_last;
		s_q.st == ST_BUSY && s_q.cnt == BUSY_CYCLES - 16'h0001 && !accept;
	endsequence
	sequence s_busy_done;
		s_q.st == ST_LOAD ##1 (!busy_o || wr_valid_o);
	endsequence
	property p_busy_end;
		s_busy_last |=> s_busy_done or wr_valid_o;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy did not clear"); // [RQ8]

	property p_write_selected;
		wr_valid_o |-> !$past(s_q.cs_q);
	endproperty
	a_write_selected: assert property (p_write_selected) else $error("write while deselected"); // [RQ1]

	property p_bus_float;
		host_data_bus_oe_o |-> !$past(rd_strobe_n_i, 2) && !$past(chip_sel_n_i, 2);
	endproperty
	a_bus_float: assert property (p_bus_float) else $error("bus driven without read"); // [RQ10]

	property p_busy_read;
		s_q.cd_q |=> host_data_bus_o == {7'h00, $past(busy_o)};
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy read wrong"); // [RQ6]

	property p_data_read;
		!s_q.cd_q |=> host_data_bus_o == $past(rd_byte_i);
	endproperty
	a_data_read: assert property (p_data_read) else $error("display read wrong"); // [RQ5]

	property p_ptr_data;
		wr_valid_o && !wr_cmd_o |-> addr_ptr_o == PTR_W'($past(addr_ptr_o) + 6'h01);
	endproperty
	a_ptr_data: assert property (p_ptr_data) else $error("pointer not advanced"); // [RQ23]

	property p_cmd_sample;
		wr_valid_o |-> wr_cmd_o == $past(s_q.cd_q);
	endproperty
	a_cmd_sample: assert property (p_cmd_sample) else $error("select sampled wrong"); // [RQ9]

	property p_serial_float;
		s_q.mode == MODE_PARALLEL |-> !serial_out_oe_o;
	endproperty
	a_serial_float: assert property (p_serial_float) else $error("serial out driven"); // [RQ15]

	property p_duty;
		duty_nine_o |-> com_enable_o == COM_EN_NINE;
	endproperty
	a_duty: assert property (p_duty) else $error("duty commons wrong"); // [RQ18]
endmodule // lcd_host_port
`default_nettype wire

// ==== verif/lcd_host_model.sv ====
// Host side model: serial shift clock and serial data towards the port.
// Assumes the bench owns chip select, the write latch and the straps.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
	// Serial pins towards the device
	output logic shift_clock_o,
	output logic serial_o,
	// Serial data back from the device
	input wire logic so_i
);
	// Bits seen on the device output at each rising shift edge
	logic [15:0] cap = 16'h0000;
	initial begin
		shift_clock_o = 1'b1;
		serial_o = 1'b0;
	end
	// Send n bits MSB first, 64 ns per bit
	task automatic send(input logic [15:0] d, input int n);
		#3;
		for (int i = n - 1; i >= 0; i--) begin
			shift_clock_o = 1'b0;
			serial_o = d[i];
			#32;
			cap = {cap[14:0], so_i};
			shift_clock_o = 1'b1;
			#32;
		end
		serial_o = ~d[0];
	endtask
endmodule // lcd_host_model
`default_nettype wire

// ==== verif/lcd_ctrl_host_interface_tb.sv ====
// Bench: parallel and serial writes, reads, pointer and straps.
// Assumes the host model drives the shift clock within frames and during reset only.
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_host_interface_tb;
	import lcd_host_pkg::*;
	localparam logic [CNT_W-1:0] BC = 16'h0020;
	localparam logic [7:0] CMDS [6] = '{8'h8A, 8'h8B, 8'h00, 8'h12, 8'h89, 8'hFF};
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cs_n = 1'b1;
	logic wr_n = 1'b1;
	logic rd_n = 1'b1;
	logic cd = 1'b0;
	logic mode = 1'b0;
	logic duty = 1'b0;
	logic b1 = 1'b0;
	logic b0 = 1'b0;
	logic [7:0] bus_i = 8'h00;
	logic [7:0] rd_byte = 8'h00;
	logic [7:0] bus_o, wr_byte;
	logic bus_oe, so, so_oe, wv, wc, busy, smode, d9, sck, si;
	logic [5:0] ptr;
	logic [5:0] eptr;
	logic [15:0] com, sd;
	logic [3:0] cmin, cmax;
	int n_fail = 0;
	int checks_done = 0;
	always #2.5 clk_i = ~clk_i;
	lcd_host_model host (.shift_clock_o(sck), .serial_o(si), .so_i(so));
	lcd_host_port #(.BUSY_CYCLES(BC)) dut (.clk_i(clk_i), .reset_i(reset_i),
		.shift_clock_in_i(sck), .chip_sel_n_i(cs_n), .wr_strobe_n_i(wr_n),
		.rd_strobe_n_i(rd_n), .cmd_data_sel_i(cd), .host_data_bus_i(bus_i),
		.host_data_bus_o(bus_o), .host_data_bus_oe_o(bus_oe), .serial_in_i(si),
		.serial_out_o(so), .serial_out_oe_o(so_oe), .port_mode_sel_i(mode),
		.duty_sel_i(duty), .contrast_range_b1_i(b1), .contrast_range_b0_i(b0),
		.wr_valid_o(wv), .wr_cmd_o(wc), .wr_byte_o(wr_byte), .addr_ptr_o(ptr),
		.busy_o(busy), .rd_byte_i(rd_byte), .serial_mode_o(smode), .duty_nine_o(d9),
		.com_enable_o(com), .contrast_min_o(cmin), .contrast_max_o(cmax));
	function automatic logic [7:0] ram(input logic [5:0] p);
		return {2'h0, p} ^ 8'h5A;
	endfunction
	function automatic logic [5:0] nxt(input logic c, input logic [7:0] b,
			input logic [5:0] p);
		if (!c) return p + 6'h1;
		if (b[7:6] == 2'h3) return b[5:0];
		if ((b & 8'hEE) == 8'h8A || (b & 8'hEC) == 8'h00) return p + 6'h1;
		return p;
	endfunction
	always @(negedge clk_i) rd_byte <= ram(ptr);
	task automatic stop_test();
		$display("checks=%0d fails=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic await(ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk_i);
			#1;
			if (s === v) return;
		end
		n_fail++;
		$display("[ERR] t=%0t timeout got=%h exp=%h", $time, s, v);
		stop_test();
	endtask
	task automatic wr(input logic c, input logic [7:0] b, input logic sel);
		@(negedge clk_i);
		cs_n = ~sel;
		cd = c;
		bus_i = mode ? ~b : b;
		wr_n = 1'b0;
		repeat (6) @(negedge clk_i);
		wr_n = 1'b1;
		if (sel) await(wv, 1'b1, 10);
		else for (int i = 0; i < 10; i++) @(negedge clk_i) chk(wv, 0);
		@(negedge clk_i);
		cs_n = 1'b1;
	endtask
	task automatic rd(input logic c, input logic sel, input logic [7:0] e);
		@(negedge clk_i);
		cs_n = ~sel;
		cd = c;
		rd_n = 1'b0;
		repeat (5) @(negedge clk_i);
		chk(bus_oe, sel & ~mode);
		chk(so_oe, sel & mode);
		if (sel & ~mode) chk(bus_o, e);
		rd_n = 1'b1;
		repeat (5) @(negedge clk_i);
		chk(bus_oe, 0);
		cs_n = 1'b1;
	endtask
	task automatic wr_check(input logic c, input logic [7:0] b, input logic rdb);
		wr(c, b, 1'b1);
		chk(wr_byte, b);
		chk(wc, c);
		eptr = nxt(c, b, eptr);
		chk(ptr, eptr);
		chk(busy, 1);
		if (rdb) rd(1'b1, 1'b1, 8'h01);
		repeat (rdb ? BC - 14 : BC - 3) @(negedge clk_i);
		chk(busy, 1);
		await(busy, 1'b0, 12);
	endtask
	task automatic do_reset(input logic m);
		@(negedge clk_i);
		reset_i = 1'b1;
		// No oscillator select or test pin here: both held inactive
		mode = m;
		duty = 1'($urandom);
		b1 = 1'($urandom);
		b0 = 1'($urandom);
		host.send(16'h0000, 4);
		repeat (16) @(negedge clk_i);
		reset_i = 1'b0;
		eptr = 6'h00;
		repeat (10) @(negedge clk_i);
		chk(smode, m);
		chk(d9, duty);
		chk(com, duty ? 16'h01FF : 16'hFFFF);
		chk(cmin, {b1, b0});
		chk(cmax, {b1, b0} + 4'h7);
		chk(ptr, 0);
		chk(busy, 0);
		$display("reset and strap test done");
	endtask
	initial begin
		void'($urandom(32'he329));
		do_reset(1'b0);
		wr_check(1'b0, 8'($urandom), 1'b1);
		rd(1'b1, 1'b1, 8'h00);
		rd(1'b0, 1'b1, ram(eptr));
		rd(1'b0, 1'b0, 8'h00);
		wr(1'b0, 8'h33, 1'b0);
		chk(ptr, eptr);
		$display("parallel write and read test done");
		wr_check(1'b1, {2'h3, 6'($urandom)}, 1'b0);
		foreach (CMDS[i]) wr_check(1'b1, CMDS[i], 1'b0);
		wr_check(1'b0, 8'($urandom), 1'b0);
		$display("pointer test done");
		do_reset(1'b1);
		sd = 16'($urandom);
		@(negedge clk_i);
		cs_n = 1'b0;
		host.send(sd, 12);
		wr_check(sd[15], sd[7:0], 1'b0);
		@(negedge clk_i);
		cs_n = 1'b0;
		host.send(16'h0000, 10);
		chk(host.cap[7:0], ram(eptr));
		@(negedge clk_i);
		cs_n = 1'b1;
		rd(1'b0, 1'b1, 8'h00);
		$display("serial test done");
		stop_test();
	end
endmodule // lcd_ctrl_host_interface_tb
`default_nettype wire
